// [rtl/ffcgc_regs.vh]
// Register map, field positions, reset values and timing counts
`ifndef FFCGC_REGS_VH
`define FFCGC_REGS_VH
`define FFCGC_ADR_CTRL 8'h00
`define FFCGC_ADR_TIME 8'h04
`define FFCGC_ADR_TEMP 8'h08
`define FFCGC_ADR_LEAD 8'h0C
`define FFCGC_ADR_STAT 8'h10
`define FFCGC_ADR_CMD 8'h14
`define FFCGC_ADR_SENSE 8'h18
// Control register fields
`define FFCGC_CTRL_FMODE_LO 0
`define FFCGC_CTRL_GMODE_LO 2
`define FFCGC_CTRL_LOG2_LO 4
`define FFCGC_CTRL_RAD 7
// FFC modes
`define FFCGC_FM_EXT 2'h0
`define FFCGC_FM_MAN 2'h1
`define FFCGC_FM_AUTO 2'h2
// Gain modes
`define FFCGC_GM_HIGH 2'h0
`define FFCGC_GM_LOW 2'h1
`define FFCGC_GM_AUTO 2'h2
// Reported FFC states
`define FFCGC_ST_NOTCMD 2'h0
`define FFCGC_ST_IMMIN 2'h1
`define FFCGC_ST_PROG 2'h2
`define FFCGC_ST_DONE 2'h3
// Reset values
`define FFCGC_LOG2_RST 3'h3
`define FFCGC_LEAD_RST 16'h0034
`define FFCGC_TIME_MIN 3
`define FFCGC_CLK_HZ 40000000
// Core cycles per millisecond tick, milliseconds per minute
`define FFCGC_TICK_CYC 40000
`define FFCGC_MS_PER_MIN 60000
`define FFCGC_TEMP_RST 16'h0096
`define FFCGC_OVH_FRAMES 8'h0F
// Lockout window, centi-degrees Celsius, signed
`define FFCGC_LOCK_LO (-16'sd1000)
`define FFCGC_LOCK_HI 16'sd8000
`endif

// [rtl/ffcgc_top.v]
// Flat-field correction scheduler and gain state controller
//
// Behaviour
// - Three FFC modes, default set by shutter
// - External mode: commanded only, shutter untouched
// - Manual mode: commanded, shutter closed throughout
// - Auto: correct at start-up and timeout
// - Auto: correct on temperature drift beyond threshold
// - Host may change time and temperature triggers
// - Four reported states, starting not commanded
// - Imminent lead frames before automatic correction
// - In progress on command; radiometry invalid
// - Default correction lasts 23 frames, 8 integrated
// - Integrated frames power of two, 1..128
// - Completion moves to complete state automatically
// - Desired flag raised on auto triggers always
// - Auto mode: desired flag enters imminent immediately
// - Outside -10..80 C lock shutter and non-external corrections
// - Report lockout; resume when temperature valid
// - High, low, auto gain modes; high default
// - Auto gain switches on hot/cold pixel share
// - Auto gain accepted only with radiometry on
// - Auto gain with non-auto FFC: no correction
//
// Register map, byte addresses
//   0x00 control: FFC mode, gain mode, log2 frames, radiometry
//   0x04 elapsed-time limit, in millisecond ticks
//   0x08 drift threshold, centi-degrees
//   0x0C imminent lead, in frames
//   0x10 status, read only
//   0x14 command, bit 0 starts a correction
//   0x18 temperature at last correction, read only
//
// Bus timing
//   Request taken on the first edge with cyc and stb
//   Ack follows one cycle later, for one cycle
//   Read data stands in the ack cycle
//   Unmapped reads give zero; unmapped writes are dropped
//
// Limitations
//   Pixel statistics arrive as two ready-made flags
//   Lockout window is inclusive at both ends
//   A correction cut by lockout keeps counting frames
//   Commands during imminent or in progress are dropped
//   Clearing the enable stops timers and bus alike
//   Time limit counts ticks so minutes fit in 32 bits
//
// Hazards
//   Desired flag is recomputed every cycle, so a trigger
//   that lands with a completion is cleared by it
//   Shutter gating is applied before completion so the
//   shutter always opens when the state reaches complete
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`include "ffcgc_regs.vh"
`default_nettype none
module ffcgc_top #(
	parameter HAS_SHUTTER = 1,
	parameter TICK_CYC = `FFCGC_TICK_CYC,
	parameter TIME_CYC = `FFCGC_TIME_MIN * `FFCGC_MS_PER_MIN
) (
	input wire mclk,
	input wire reset,
	input wire ce,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire frame_sync,
	input wire signed [15:0] cam_temp,
	input wire hot_exceed,
	input wire cold_exceed,
	output reg [1:0] ffc_state,
	output reg ffc_desired,
	output reg shutter_lockout,
	output reg shutter_close,
	output reg rad_invalid,
	output reg gain_low
);
	// Sequencer states, one-hot
	localparam S_IDLE = 4'h1;
	localparam S_IMM = 4'h2;
	localparam S_RUN = 4'h4;
	localparam S_DONE = 4'h8;
	localparam [1:0] FM_RST = HAS_SHUTTER ? `FFCGC_FM_AUTO : `FFCGC_FM_EXT;

	reg [1:0] fmode;
	reg [1:0] gmode;
	reg [2:0] log2_int;
	reg rad_en;
	reg [31:0] time_lim;
	reg [15:0] temp_thr;
	reg [15:0] lead;
	reg [3:0] state;
	reg [31:0] tcnt;
	reg [31:0] pcnt;
	reg [15:0] fcnt;
	reg signed [15:0] temp_last;
	reg startup;
	reg shut_run;
	wire [31:0] wmask;
	wire acc;
	wire cmd_wr;
	wire signed [16:0] tdiff;
	wire [15:0] tabs;
	wire time_hit;
	wire tick;
	wire temp_hit;
	wire lock_now;
	wire trig;
	wire [15:0] run_len;
	wire cmd_ok;

	// Byte-lane write mask, one lane per select bit
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : lane
			assign wmask[g*8+7:g*8] = {8{wb_sel_i[g]}};
		end
	endgenerate

	assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign cmd_wr = acc & wb_we_i & (wb_adr_i == `FFCGC_ADR_CMD) &
		wb_sel_i[0] & wb_dat_i[0];
	assign tdiff = {cam_temp[15], cam_temp} - {temp_last[15], temp_last};
	assign tabs = tdiff[16] ? (16'h0000 - tdiff[15:0]) : tdiff[15:0];
	assign temp_hit = tabs > temp_thr;
	// Millisecond tick for the elapsed-time trigger
	assign tick = pcnt == TICK_CYC - 1;
	assign time_hit = tcnt >= time_lim;
	assign lock_now = (cam_temp < `FFCGC_LOCK_LO) ||
		(cam_temp > `FFCGC_LOCK_HI);
	assign trig = startup | time_hit | temp_hit;
	assign run_len = {8'h00, `FFCGC_OVH_FRAMES} + (16'h0001 << log2_int);
	// commands ignored under lockout except external
	assign cmd_ok = (fmode == `FFCGC_FM_EXT) | ~shutter_lockout;

	// Register writes
	always @(posedge mclk) begin
		if (reset) begin
			fmode <= FM_RST;
			gmode <= `FFCGC_GM_HIGH;
			log2_int <= `FFCGC_LOG2_RST;
			rad_en <= 1'b0;
			time_lim <= TIME_CYC;
			temp_thr <= `FFCGC_TEMP_RST;
			lead <= `FFCGC_LEAD_RST;
		end else if (ce && acc && wb_we_i) begin
			if (wb_adr_i == `FFCGC_ADR_CTRL) begin
				if (wb_sel_i[0])
					fmode <= wb_dat_i[1:0];
				if (wb_sel_i[0] && (wb_dat_i[3:2] != `FFCGC_GM_AUTO ||
						wb_dat_i[`FFCGC_CTRL_RAD]))
					gmode <= wb_dat_i[3:2];
				if (wb_sel_i[0])
					log2_int <= wb_dat_i[6:4];
				if (wb_sel_i[0])
					rad_en <= wb_dat_i[`FFCGC_CTRL_RAD];
			end else if (wb_adr_i == `FFCGC_ADR_TIME) begin
				time_lim <= (time_lim & ~wmask) | (wb_dat_i & wmask);
			end else if (wb_adr_i == `FFCGC_ADR_TEMP) begin
				temp_thr <= (temp_thr & ~wmask[15:0]) |
					(wb_dat_i[15:0] & wmask[15:0]);
			end else if (wb_adr_i == `FFCGC_ADR_LEAD) begin
				lead <= (lead & ~wmask[15:0]) |
					(wb_dat_i[15:0] & wmask[15:0]);
			end
		end
	end

	// Bus answer: one cycle ack, unmapped reads return zero
	always @(posedge mclk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (ce) begin
			wb_ack_o <= acc;
			if (wb_adr_i == `FFCGC_ADR_CTRL)
				wb_dat_o <= {24'h000000, rad_en, log2_int, gmode, fmode};
			else if (wb_adr_i == `FFCGC_ADR_TIME)
				wb_dat_o <= time_lim;
			else if (wb_adr_i == `FFCGC_ADR_TEMP)
				wb_dat_o <= {16'h0000, temp_thr};
			else if (wb_adr_i == `FFCGC_ADR_LEAD)
				wb_dat_o <= {16'h0000, lead};
			else if (wb_adr_i == `FFCGC_ADR_STAT)
				wb_dat_o <= {25'h0000000, gain_low, rad_invalid,
					shutter_close, shutter_lockout, ffc_desired, ffc_state};
			else if (wb_adr_i == `FFCGC_ADR_SENSE)
				wb_dat_o <= {16'h0000, temp_last};
			else
				wb_dat_o <= 32'h00000000;
		end
	end

	// Correction sequencer
	always @(posedge mclk) begin
		if (reset) begin
			state <= S_IDLE;
			ffc_state <= `FFCGC_ST_NOTCMD;
			ffc_desired <= 1'b0;
			pcnt <= 32'h00000000;
			shutter_lockout <= 1'b0;
			shutter_close <= 1'b0;
			rad_invalid <= 1'b0;
			tcnt <= 32'h00000000;
			fcnt <= 16'h0000;
			temp_last <= 16'sh0000;
			startup <= 1'b1;
			shut_run <= 1'b0;
		end else if (ce) begin
			shutter_lockout <= lock_now;
			if (tick)
				pcnt <= 32'h00000000;
			else
				pcnt <= pcnt + 32'h00000001;
			if (!time_hit && tick)
				tcnt <= tcnt + 32'h00000001;
			ffc_desired <= trig;
			case (state)
			S_IDLE, S_DONE: begin
				if (cmd_wr && cmd_ok) begin
					state <= S_RUN;
					ffc_state <= `FFCGC_ST_PROG;
					rad_invalid <= 1'b1;
					fcnt <= 16'h0000;
					shut_run <= fmode != `FFCGC_FM_EXT;
					shutter_close <= fmode != `FFCGC_FM_EXT;
				// no auto correction in other modes
				end else if (fmode == `FFCGC_FM_AUTO && trig &&
						!shutter_lockout) begin
					state <= S_IMM;
					ffc_state <= `FFCGC_ST_IMMIN;
					fcnt <= 16'h0000;
				end
			end
			S_IMM: begin
				if (shutter_lockout || fmode != `FFCGC_FM_AUTO) begin
					state <= S_IDLE;
					ffc_state <= `FFCGC_ST_NOTCMD;
				end else if (frame_sync) begin
					if (fcnt + 16'h0001 >= lead) begin
						state <= S_RUN;
						ffc_state <= `FFCGC_ST_PROG;
						rad_invalid <= 1'b1;
						shut_run <= 1'b1;
						shutter_close <= 1'b1;
						fcnt <= 16'h0000;
					end else
						fcnt <= fcnt + 16'h0001;
				end
			end
			S_RUN: begin
				if (lock_now)
					shutter_close <= 1'b0;
				else
					shutter_close <= shut_run;
				if (frame_sync) begin
					if (fcnt + 16'h0001 >= run_len) begin
						state <= S_DONE;
						ffc_state <= `FFCGC_ST_DONE;
						rad_invalid <= 1'b0;
						shutter_close <= 1'b0;
						shut_run <= 1'b0;
						startup <= 1'b0;
						tcnt <= 32'h00000000;
						temp_last <= cam_temp;
					end else
						fcnt <= fcnt + 16'h0001;
				end
			end
			default: begin
				state <= S_IDLE;
				ffc_state <= `FFCGC_ST_NOTCMD;
			end
			endcase
		end
	end

	// Gain state selection
	always @(posedge mclk) begin
		if (reset)
			gain_low <= 1'b0;
		else if (ce) begin
			if (gmode == `FFCGC_GM_LOW)
				gain_low <= 1'b1;
			else if (gmode == `FFCGC_GM_HIGH)
				gain_low <= 1'b0;
			else if (!gain_low && hot_exceed)
				gain_low <= 1'b1;
			else if (gain_low && cold_exceed)
				gain_low <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [dv/ffcgc_scene.sv]
// Frame pulse and temperature source
`default_nettype none
module ffcgc_scene (
	input wire logic mclk,
	input wire logic signed [15:0] temp_set,
	output var logic frame_sync = 1'h0,
	output var logic signed [15:0] cam_temp = 16'sh09C4
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	// host side supplies scene temperature
	// One pulse every 20 cycles
	always @(posedge mclk) begin
		n <= n == 19 ? 0 : n + 1;
		frame_sync <= n == 19;
		cam_temp <= temp_set;
	end
endmodule
`default_nettype wire

// [dv/ffcgc_chk.sv]
// Port assertions
`default_nettype none
module ffcgc_chk (
	input wire mclk,
	input wire reset,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire wb_ack_o,
	input wire signed [15:0] cam_temp,
	input wire [1:0] ffc_state,
	input wire ffc_desired,
	input wire shutter_lockout,
	input wire shutter_close,
	input wire rad_invalid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Request, then start command at ack
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_cmd;
		s_req ##0 (ffc_state[0] == ffc_state[1] && !shutter_lockout)
		##1 (wb_ack_o && wb_we_i && wb_adr_i == 8'h14 && wb_dat_i[0]);
	endsequence
	property p_ack; s_req |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack held");
	property p_cmd; s_cmd |-> ##[0:1] ffc_state == 2'h2; endproperty
	a_cmd: assert property (p_cmd) else $error("no start");
	property p_rinv; rad_invalid == (ffc_state == 2'h2); endproperty
	a_rinv: assert property (p_rinv) else $error("invalid");
	property p_shut; shutter_close |-> ffc_state == 2'h2; endproperty
	a_shut: assert property (p_shut) else $error("shutter");
	property p_lock; !$past(reset) && $stable(cam_temp) |-> shutter_lockout
		== (cam_temp < 16'shFC18 || cam_temp > 16'sh1F40);
	endproperty
	a_lock: assert property (p_lock) else $error("lockout");
	property p_done; !$past(reset) && $past(ffc_state) == 2'h2
		&& ffc_state != 2'h2 |-> ffc_state == 2'h3;
	endproperty
	a_done: assert property (p_done) else $error("not done");
	property p_start; $fell(reset) |-> ##[0:1] ffc_desired; endproperty
	a_start: assert property (p_start) else $error("desired");
endmodule
bind ffcgc_top ffcgc_chk u_ffcgc_chk (.mclk(mclk), .reset(reset),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.cam_temp(cam_temp), .ffc_state(ffc_state), .ffc_desired(ffc_desired),
	.shutter_lockout(shutter_lockout), .shutter_close(shutter_close),
	.rad_invalid(rad_invalid));
`default_nettype wire

// [dv/tb_top.sv]
// Bench for the FFC controller
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, reset = 1, cyc = 0, we = 0, hot = 0, cold = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, rd, dato;
	logic signed [15:0] tset = 16'sh09C4, temp;
	logic fs, ack, des, lock, shut, rinv, glow;
	logic [1:0] st;
	int n_fail = 0, compares = 0, nf, k;
	logic [39:0] rows [5] = '{{8'h00, 32'h32}, {8'h0C, 32'h34},
		{8'h08, 32'h96}, {8'h04, 32'h7D0}, {8'h1C, 32'h0}};
	logic [7:0] gv [4] = '{8'h39, 8'hB9, 8'h31, 8'h35};
	ffcgc_scene u_ffcgc_scene (.mclk(mclk), .temp_set(tset), .frame_sync(fs),
		.cam_temp(temp));
	ffcgc_top #(.TICK_CYC(1), .TIME_CYC(2000)) u_ffcgc_top (.mclk(mclk),
		.reset(reset),
		.ce(1'h1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dato),
		.wb_ack_o(ack), .frame_sync(fs), .cam_temp(temp), .hot_exceed(hot),
		.cold_exceed(cold), .ffc_state(st), .ffc_desired(des),
		.shutter_lockout(lock), .shutter_close(shut), .rad_invalid(rinv),
		.gain_low(glow));
	task automatic chk(logic [31:0] g, e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: %h %h", $time, g, e);
		end
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge mclk);
		cyc <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		do @(posedge mclk); while (ack !== 1'h1);
		rd = dato;
		cyc <= 0;
		@(negedge mclk);
	endtask
	task automatic run(logic [1:0] s);
		nf = 0;
		for (int i = 0; i < 4000 && st !== s; i++) begin
			nf += fs;
			@(negedge mclk);
		end
	endtask
	task automatic wt;
		repeat (4) @(negedge mclk);
	endtask
	task automatic complete_run;
		$display("fails %0d of %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Clock and watchdog
	initial forever #12.5 mclk = ~mclk;
	initial begin
		#500000;
		n_fail++;
		complete_run();
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge mclk);
		reset <= 0;
		for (k = 0; k < 5; k++) begin
			bus(0, rows[k][39:32], 0);
			chk(rd, rows[k][31:0]);
		end
		bus(1, 8'h0C, 2);
		bus(0, 8'h0C, 0);
		chk(rd, 2);
		run(2'h3);
		@(posedge mclk);
		tset <= 16'sh0A8C;
		run(2'h1);
		chk(des, 1);
		run(2'h2);
		chk(nf, 2);
		run(2'h3);
		chk(nf, 23);
		wt;
		chk(des, 0);
		for (k = 0; k < 2; k++) begin
			bus(1, 8'h00, k ? 8'h71 : 8'h00);
			bus(1, 8'h14, 1);
			chk(rinv, 1);
			chk(shut, k);
			run(2'h3);
			chk(nf, k ? 143 : 16);
		end
		@(posedge mclk);
		tset <= 16'shFBB4;
		wt;
		chk(lock, 1);
		chk(des, 1);
		bus(1, 8'h14, 1);
		chk(st, 3);
		@(posedge mclk);
		tset <= 16'sh0A8C;
		hot <= 1;
		wt;
		chk(lock, 0);
		for (k = 0; k < 4; k++) begin
			bus(1, 8'h00, gv[k]);
			wt;
			chk(glow, k[0]);
		end
		chk(st, 3);
		bus(1, 8'h00, 8'hB9);
		@(posedge mclk);
		hot <= 0;
		cold <= 1;
		wt;
		chk(glow, 0);
		// Second reset in mid-run
		@(posedge mclk);
		reset <= 1;
		repeat (2) @(posedge mclk);
		reset <= 0;
		@(negedge mclk);
		chk(st, 0);
		chk(des, 0);
		@(negedge mclk);
		chk(des, 1);
		bus(0, 8'h00, 0);
		chk(rd, 32'h32);
		complete_run();
	end
endmodule
`default_nettype wire
